// ### core/thrb_regs.sv
// Host register bank of a dual-redundant serial bus terminal (upper register map)
`timescale 1ns/100ps
`include "thrb_defines.svh"

module thrb_regs (
  input  logic                 ref_clk,
  input  logic                 rst_b,
  // Register port behind the host target
  input  logic [6:0]           reg_addr,
  input  logic                 reg_wr,
  input  logic                 reg_rd,
  input  logic [15:0]          reg_wdata,
  output logic [15:0]          reg_rdata,
  output logic                 reg_rack,
  // Protocol core side
  input  thrb_pkg::thrb_mode_t op_mode,
  input  logic [15:0]          rt_status_in,
  input  logic [15:0]          rt_selftest_in,
  input  logic [6:0]           cond_in,
  input  logic [7:0]           gp_set_in,
  input  logic [7:0]           gp_clr_in,
  input  logic                 cmd_valid,
  input  logic [15:0]          cmd_word,
  input  logic                 dstack_wr,
  input  logic [15:0]          dstack_addr_in,
  input  logic                 frame_start,
  input  logic                 msg_load,
  input  logic [15:0]          msg_gap_in,
  input  logic                 ram_test_busy,
  input  logic                 ram_test_done,
  input  logic                 ram_test_pass,
  input  logic [15:0]          ipend2_event,
  input  logic                 ipend2_clear,
  input  logic                 ipend1_pending,
  input  logic                 isq_event,
  input  logic                 isq_valid_msg,
  input  logic [15:0]          isq_word,
  output logic [15:0]          ext_cfg_a,
  output logic [15:0]          ext_cfg_b,
  output logic [7:0]           gp_flags,
  output logic                 frame_done,
  output logic                 isq_wr,
  output logic [15:0]          isq_addr,
  output logic [15:0]          isq_data
);

  // ****************************************
  // Timing constants
  // ****************************************
  localparam int          US_CYC_I    = `THRB_CLK_MHZ * `THRB_MSG_LSB_US;
  localparam int          FRAME_CYC_I = `THRB_CLK_MHZ * `THRB_FRAME_LSB_US;
  localparam logic [11:0] US_CYC      = US_CYC_I[11:0];
  localparam logic [11:0] FRAME_CYC   = FRAME_CYC_I[11:0];

  function automatic logic thrb_hit(input logic [6:0] a, input logic [6:0] off);
    return a == off;
  endfunction : thrb_hit
  function automatic logic [7:0] thrb_gp_update(input logic [7:0] cur,
                                                input logic [7:0] clr,
                                                input logic [7:0] set);
    // Set beats clear when both name the same flag
    return (cur & ~clr) | set;
  endfunction : thrb_gp_update

  // ****************************************
  // Reset release
  // ****************************************
  logic       rst_meta, rst_n;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  logic        wr_dstack, wr_frame, wr_ftlc, wr_cfg_a, wr_cfg_b, wr_flag, wr_ien2, wr_qptr;
  assign wr_dstack = reg_wr && thrb_hit(reg_addr, `THRB_OFF_DSTACK);
  assign wr_frame  = reg_wr && thrb_hit(reg_addr, `THRB_OFF_FRAME_REM);
  assign wr_ftlc   = reg_wr && thrb_hit(reg_addr, `THRB_OFF_FT_LC_TRG);
  assign wr_cfg_a  = reg_wr && thrb_hit(reg_addr, `THRB_OFF_CFG_A);
  assign wr_cfg_b  = reg_wr && thrb_hit(reg_addr, `THRB_OFF_CFG_B);
  assign wr_flag   = reg_wr && thrb_hit(reg_addr, `THRB_OFF_COND_FLAG);
  assign wr_ien2   = reg_wr && thrb_hit(reg_addr, `THRB_OFF_IEN2);
  assign wr_qptr   = reg_wr && thrb_hit(reg_addr, `THRB_OFF_QPTR);

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_cfg_a <= `THRB_CFG_A_RST;
      ext_cfg_b <= `THRB_ZERO16;
    end else begin
      if (wr_cfg_a) begin
        ext_cfg_a <= reg_wdata & `THRB_CFG_A_WMASK;
      end
      if (wr_cfg_b) begin
        ext_cfg_b <= reg_wdata & `THRB_CFG_B_WMASK;
      end
    end
  end

  // ****************************************
  // Data stack, frame time / last command / trigger
  // ****************************************
  logic [15:0] data_stack_address, frame_time_last_command_trigger;
  // A host write wins over a core update in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_stack_address <= `THRB_ZERO16;
    end else if (wr_dstack) begin
      data_stack_address <= reg_wdata;
    end else if (dstack_wr && op_mode != thrb_pkg::THRB_MODE_BC) begin
      data_stack_address <= dstack_addr_in;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_time_last_command_trigger <= `THRB_ZERO16;
    end else if (wr_ftlc) begin
      frame_time_last_command_trigger <= reg_wdata;
    end else if (cmd_valid && op_mode == thrb_pkg::THRB_MODE_RT) begin
      frame_time_last_command_trigger <= cmd_word;
    end
  end

  // ****************************************
  // Frame and message timers
  // ****************************************
  logic [11:0] us_cnt, frame_cnt;
  logic        us_tick, frame_tick;
  logic [15:0] frame_time_remaining, message_time_remaining;
  assign us_tick    = us_cnt == US_CYC - 12'h001;
  assign frame_tick = frame_cnt == FRAME_CYC - 12'h001;
  // Prescalers restart with each load so the first count is a full period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      us_cnt <= 12'h000;
    end else if (us_tick || msg_load) begin
      us_cnt <= 12'h000;
    end else begin
      us_cnt <= us_cnt + 12'h001;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt <= 12'h000;
    end else if (frame_tick || frame_start || wr_frame) begin
      frame_cnt <= 12'h000;
    end else begin
      frame_cnt <= frame_cnt + 12'h001;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_time_remaining <= `THRB_ZERO16;
      frame_done           <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (wr_frame) begin
        frame_time_remaining <= reg_wdata;
      end else if (frame_start) begin
        frame_time_remaining <= frame_time_last_command_trigger;
      end else if (frame_tick && frame_time_remaining != `THRB_ZERO16) begin
        frame_time_remaining <= frame_time_remaining - `THRB_ONE16;
        frame_done           <= frame_time_remaining == `THRB_ONE16;
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      message_time_remaining <= `THRB_ZERO16;
    end else if (msg_load) begin
      message_time_remaining <= msg_gap_in;
    end else if (us_tick && message_time_remaining != `THRB_ZERO16) begin
      message_time_remaining <= message_time_remaining - `THRB_ONE16;
    end
  end

  // ****************************************
  // General-purpose flags
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gp_flags <= 8'h00;
    end else if (wr_flag) begin
      // Engine sets still land during a host write
      gp_flags <= thrb_gp_update(gp_flags,
                                 reg_wdata[`THRB_GP_CLR_HI:`THRB_GP_CLR_LO],
                                 reg_wdata[`THRB_GP_SET_HI:`THRB_GP_SET_LO] | gp_set_in);
    end else begin
      gp_flags <= thrb_gp_update(gp_flags, gp_clr_in, gp_set_in);
    end
  end

  // ****************************************
  // RAM self-test status and second interrupt pair
  // ****************************************
  logic [15:0] ram_self_test_status, interrupt_enable_second;
  logic [15:0] interrupt_pending_second, ev_masked;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_self_test_status <= `THRB_ZERO16;
    end else begin
      ram_self_test_status <= {8'h00, ram_test_done, ram_test_busy, ram_test_pass, 5'h00};
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_enable_second <= `THRB_ZERO16;
    end else if (wr_ien2) begin
      interrupt_enable_second <= reg_wdata & `THRB_IPEND2_EVMASK;
    end
  end
  assign ev_masked = ipend2_event & interrupt_enable_second & `THRB_IPEND2_EVMASK;
  // Event bits are sticky; an event in the clearing cycle survives
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_pending_second <= `THRB_ZERO16;
    end else begin
      interrupt_pending_second[14:1] <= (ipend2_clear ? 14'h0000
                                        : interrupt_pending_second[14:1])
                                        | ev_masked[14:1];
      interrupt_pending_second[`THRB_IPEND2_CHAIN]  <= ipend1_pending;
      interrupt_pending_second[`THRB_IPEND2_MASTER] <= (|ev_masked[14:1])
                                        || ipend1_pending
                                        || (!ipend2_clear && (|interrupt_pending_second[14:1]));
    end
  end

  // ****************************************
  // Queue pointer and queue writes
  // ****************************************
  logic [15:0] queue_pointer;
  logic        isq_take;
  // Controller mode pushes unfiltered to the general queue
  always_comb begin
    isq_take = 1'b0;
    unique case (op_mode)
      thrb_pkg::THRB_MODE_BC: isq_take = isq_event;
      thrb_pkg::THRB_MODE_RT,
      thrb_pkg::THRB_MODE_MT: begin
        isq_take = isq_event && ext_cfg_a[`THRB_CFG_A_ISQ_EN]
                   && (!isq_word[0]
                       || (isq_valid_msg ? !ext_cfg_a[`THRB_CFG_A_ISQ_DVAL]
                                         : !ext_cfg_a[`THRB_CFG_A_ISQ_DINV]));
      end
      default: isq_take = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      isq_wr   <= 1'b0;
      isq_addr <= `THRB_ZERO16;
      isq_data <= `THRB_ZERO16;
    end else begin
      isq_wr <= isq_take;
      if (isq_take) begin
        isq_addr <= queue_pointer;
        isq_data <= isq_word;
      end
    end
  end
  // A host write to the pointer wins over the post-write advance
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      queue_pointer <= `THRB_ZERO16;
    end else if (wr_qptr) begin
      queue_pointer <= reg_wdata;
    end else if (isq_take) begin
      queue_pointer <= queue_pointer + `THRB_ONE16;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = `THRB_ZERO16;
    case (reg_addr)
      `THRB_OFF_DSTACK:    next_rdata = data_stack_address;
      `THRB_OFF_FRAME_REM: next_rdata = frame_time_remaining;
      `THRB_OFF_MSG_REM:   next_rdata = message_time_remaining;
      `THRB_OFF_FT_LC_TRG: next_rdata = frame_time_last_command_trigger;
      `THRB_OFF_RT_STATUS: next_rdata = rt_status_in & `THRB_RT_STAT_MASK;
      `THRB_OFF_RT_SELFT:  next_rdata = rt_selftest_in;
      `THRB_OFF_CFG_A:     next_rdata = ext_cfg_a;
      `THRB_OFF_CFG_B:     next_rdata = ext_cfg_b;
      `THRB_OFF_COND_FLAG: next_rdata = {1'b1, cond_in, gp_flags};
      `THRB_OFF_RAM_TEST:  next_rdata = ram_self_test_status;
      `THRB_OFF_IEN2:      next_rdata = interrupt_enable_second;
      `THRB_OFF_IPEND2:    next_rdata = interrupt_pending_second;
      `THRB_OFF_QPTR:      next_rdata = queue_pointer;
      default:             next_rdata = `THRB_ZERO16;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `THRB_ZERO16;
      reg_rack  <= 1'b0;
    end else begin
      reg_rack <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking thrb_cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_cfg_reset;
    $rose(rst_n) |-> ext_cfg_a == `THRB_CFG_A_RST && ext_cfg_b == `THRB_ZERO16;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset value wrong");
  property p_gp_write;
    wr_flag && gp_set_in == 8'h00 |=>
      gp_flags == (($past(gp_flags) & ~$past(reg_wdata[15:8])) | $past(reg_wdata[7:0]));
  endproperty
  a_gp_write: assert property (p_gp_write) else $error("flag set/clear wrong");
  property p_rt_status_zero;
    reg_rd && reg_addr == `THRB_OFF_RT_STATUS |=> reg_rack && reg_rdata[15:11] == 5'h00
                                                 && reg_rdata[7:5] == 3'h0;
  endproperty
  a_rt_status_zero: assert property (p_rt_status_zero) else $error("status reserved set");
  // The status copy adds one register stage ahead of the read register
  property p_ram_test_zero;
    reg_rd && reg_addr == `THRB_OFF_RAM_TEST |=> (reg_rdata & ~`THRB_RAM_TEST_MASK) == 16'h0000
                                                && reg_rdata[7] == $past(ram_test_done, 2);
  endproperty
  a_ram_test_zero: assert property (p_ram_test_zero) else $error("ram test read wrong");
  property p_ipend_set;
    ipend2_event[`THRB_IPEND2_SELFT] && interrupt_enable_second[`THRB_IPEND2_SELFT] |=>
      interrupt_pending_second[`THRB_IPEND2_SELFT] && interrupt_pending_second[15];
  endproperty
  a_ipend_set: assert property (p_ipend_set) else $error("second status not set");
  property p_chain;
    ipend1_pending |=> interrupt_pending_second[0] && interrupt_pending_second[15];
  endproperty
  a_chain: assert property (p_chain) else $error("chain bit missing");
  property p_isq_filter;
    isq_event && op_mode == thrb_pkg::THRB_MODE_RT && isq_word[0] && isq_valid_msg
      && ext_cfg_a[`THRB_CFG_A_ISQ_DVAL] |=> !isq_wr;
  endproperty
  a_isq_filter: assert property (p_isq_filter) else $error("filtered entry written");
  property p_qptr_advance;
    isq_wr && !$past(wr_qptr) |-> queue_pointer == isq_addr + `THRB_ONE16;
  endproperty
  a_qptr_advance: assert property (p_qptr_advance) else $error("pointer not advanced");
  property p_msg_tick;
    us_tick && !msg_load && message_time_remaining != 16'h0000 |=>
      message_time_remaining == $past(message_time_remaining) - 16'h0001 ##1 !us_tick[*8];
  endproperty
  a_msg_tick: assert property (p_msg_tick) else $error("message timer step wrong");
  property p_frame_tick;
    frame_tick |=> !frame_tick[*8];
  endproperty
  a_frame_tick: assert property (p_frame_tick) else $error("frame tick too close");
  c_frame_done: cover property (frame_done);
  c_isq_write:  cover property (isq_wr && isq_data[0]);
  c_gp_clash:   cover property (wr_flag && (reg_wdata[15:8] & reg_wdata[7:0]) != 8'h00);
  c_set_clear:  cover property (ipend2_clear && |ev_masked);

endmodule : thrb_regs

// ### core/thrb_defines.svh
// Offsets, field positions, reset values and timing constants of the terminal register bank
`ifndef THRB_DEFINES_SVH
`define THRB_DEFINES_SVH
// Byte offsets of the upper register map
`define THRB_OFF_DSTACK     7'h28
`define THRB_OFF_FRAME_REM  7'h2C
`define THRB_OFF_MSG_REM    7'h30
`define THRB_OFF_FT_LC_TRG  7'h34
`define THRB_OFF_RT_STATUS  7'h38
`define THRB_OFF_RT_SELFT   7'h3C
`define THRB_OFF_CFG_A      7'h60
`define THRB_OFF_CFG_B      7'h64
`define THRB_OFF_COND_FLAG  7'h6C
`define THRB_OFF_RAM_TEST   7'h70
`define THRB_OFF_IEN2       7'h74
`define THRB_OFF_IPEND2     7'h78
`define THRB_OFF_QPTR       7'h7C
// Reset values, constants, and write and read masks
`define THRB_ZERO16         16'h0000
`define THRB_ONE16          16'h0001
`define THRB_CFG_A_RST      16'h4000
`define THRB_CFG_A_WMASK    16'hFFF7
`define THRB_CFG_B_WMASK    16'hFC1F
`define THRB_RT_STAT_MASK   16'h071F
`define THRB_RAM_TEST_MASK  16'h00E0
`define THRB_IPEND2_EVMASK  16'h7FFE
// Field positions
`define THRB_CFG_A_ISQ_DINV 8
`define THRB_CFG_A_ISQ_DVAL 7
`define THRB_CFG_A_ISQ_EN   6
`define THRB_IPEND2_MASTER  15
`define THRB_IPEND2_SELFT   1
`define THRB_IPEND2_CHAIN   0
`define THRB_GP_CLR_HI      15
`define THRB_GP_CLR_LO      8
`define THRB_GP_SET_HI      7
`define THRB_GP_SET_LO      0
// Timing: reference clock and timer resolutions
`define THRB_CLK_MHZ        25
`define THRB_MSG_LSB_US     1
`define THRB_FRAME_LSB_US   100
`endif

// ### core/thrb_pkg.sv
// Types of the terminal register bank: operating modes and RAM word layouts
package thrb_pkg;

  typedef enum logic [2:0] {
    THRB_MODE_BC = 3'h1,
    THRB_MODE_RT = 3'h2,
    THRB_MODE_MT = 3'h4
  } thrb_mode_t;

  // Controller block status word
  typedef struct packed {
    logic       end_of_message, start_of_message, channel_b, error, status_set, format_error;
    logic       no_response, loop_fail, masked_status_set;
    logic [1:0] retry_count;
    logic       good_transfer, wrong_addr_no_gap, word_count_error, sync_type, invalid_word;
  } thrb_bc_bsw_t;

  // Terminal block status word
  typedef struct packed {
    logic       end_of_message, start_of_message, channel_b, error, t2t_format, format_error;
    logic       no_response, loop_fail, stack_rollover, illegal_command, word_count, data_sync;
    logic       invalid_word;
    logic [2:0] transfer_errors;
  } thrb_rt_bsw_t;

  // Word monitor identification word
  typedef struct packed {
    logic [7:0] gap_time;
    logic       word_flag, this_terminal, broadcast, error, command_data, channel_b;
    logic       contiguous_gap, mode_code;
  } thrb_wm_id_t;

  // Message monitor block status word
  typedef struct packed {
    logic       end_of_message, start_of_message, channel_b, error, t2t_transfer, format_error;
    logic       no_response, good_data_block, stack_rollover, reserved, word_count, sync;
    logic       invalid_word;
    logic [2:0] transfer_errors;
  } thrb_mm_bsw_t;

  // Interrupt status queue entry for a message event
  typedef struct packed {
    logic       tx_timeout, illegal_command, mon_data_half, mon_data_roll, cbuf_half, cbuf_roll;
    logic       mon_cmd_half, mon_cmd_roll, rt_cmd_half, rt_cmd_roll;
    logic [4:0] low_events;
    logic       message_event;
  } thrb_isq_msg_t;

endpackage : thrb_pkg

// ### test/thrb_host.sv
// Host processor model: strobe reads and writes
`timescale 1ns/100ps
module thrb_host (
  input  logic        ref_clk,
  output logic [6:0]  reg_addr,
  output logic        reg_wr,
  output logic        reg_rd,
  output logic [15:0] reg_wdata,
  input  logic [15:0] reg_rdata,
  input  logic        reg_rack
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 25'h0000000;
  // A released bus shows the inverse of the last request, so stale values never match
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge ref_clk);
    {reg_addr, reg_rd} = {~a, 1'b0};
    d = reg_rack ? reg_rdata : 16'hXXXX;
  endtask : rd
endmodule : thrb_host

// ### test/tb_terminal_host_register_bank.sv
// Self-checking testbench of the terminal host register bank
`timescale 1ns/100ps
module tb_terminal_host_register_bank;
  logic        ref_clk = 1'b0, rst_b = 1'b0, cmdv = 1'b0, mload = 1'b0, i2clr = 1'b0;
  logic        ip1 = 1'b0, isqe = 1'b0, isqv = 1'b0, reg_wr, reg_rd, reg_rack, frame_done, isq_wr;
  logic        dsw = 1'b0;
  logic [2:0]  ram = 3'h0;
  logic [15:0] cfga, cfgb;
  logic [6:0]  cond = 7'h00, reg_addr;
  logic [7:0]  gp_flags, fl = 8'h00;
  logic [15:0] rt_st = 16'h0000, rt_bt = 16'h0000, cmd = 16'h0000, gap = 16'h0000, d, p;
  logic [15:0] ev = 16'h0000, isqw = 16'h0000, reg_wdata, reg_rdata, isq_addr, isq_data;
  int          errors = 0, n_tests = 0, n;
  logic [6:0]  offs [5] = '{7'h28, 7'h34, 7'h7C, 7'h60, 7'h64};
  logic [15:0] msk [5] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFF7, 16'hFC1F};
  thrb_pkg::thrb_mode_t op_mode = thrb_pkg::THRB_MODE_RT;
  always #20 ref_clk = ~ref_clk;
  thrb_host thrb_host_i (.ref_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rack);
  thrb_regs thrb_regs_i (.ref_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rack, .op_mode, .rt_status_in(rt_st), .rt_selftest_in(rt_bt), .cond_in(cond),
    .gp_set_in(8'h00), .gp_clr_in(8'h00), .cmd_valid(cmdv), .cmd_word(cmd), .dstack_wr(dsw),
    .dstack_addr_in(cmd), .frame_start(1'b0), .msg_load(mload), .msg_gap_in(gap),
    .ram_test_busy(ram[2]), .ram_test_done(ram[1]), .ram_test_pass(ram[0]), .ipend2_event(ev),
    .ipend2_clear(i2clr), .ipend1_pending(ip1), .isq_event(isqe), .isq_valid_msg(isqv),
    .isq_word(isqw), .ext_cfg_a(cfga), .ext_cfg_b(cfgb), .gp_flags, .frame_done, .isq_wr,
    .isq_addr, .isq_data);
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    errors += int'(g !== e);
    if (g !== e) $display("Error %s expected %h seen %h", s, e, g);
  endtask : chk
  task rchk(input logic [6:0] a, input logic [15:0] e);
    logic [15:0] v;
    thrb_host_i.rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask : rchk
  task stop_test;
    $display("n_tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  initial begin
    d = 16'($urandom(32'h018E));
    repeat (8) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    rchk(7'h60, 16'h4000);
    chk("ext_cfg_a", 16'h4000, cfga);
    foreach (offs[i]) begin
      d = 16'($urandom());
      thrb_host_i.wr(offs[i], d);
      rchk(offs[i], d & msk[i]);
    end
    chk("ext_cfg_b", d & 16'hFC1F, cfgb);
    thrb_host_i.wr(7'h68, d);
    rchk(7'h68, 16'h0000);
    {rt_st, rt_bt} = 32'($urandom());
    {cond, ram} = 10'($urandom());
    rchk(7'h38, rt_st & 16'h071F);
    rchk(7'h3C, rt_bt);
    rchk(7'h70, {8'h00, ram[1], ram[2], ram[0], 5'h00});
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 16'h00FF : 16'($urandom());
      thrb_host_i.wr(7'h6C, d);
      fl = (fl & ~d[15:8]) | d[7:0];
      chk("gp_flags", {8'h00, fl}, {8'h00, gp_flags});
    end
    rchk(7'h6C, {1'b1, cond, fl});
    {cmd, cmdv, dsw} = {16'($urandom()), 2'b11};
    @(negedge ref_clk);
    {cmdv, dsw} = 2'b00;
    rchk(7'h34, cmd);
    rchk(7'h28, cmd);
    $display("Test registers done");
    p = 16'h0002 | (16'h0001 << (1 + $urandom() % 14));
    thrb_host_i.wr(7'h74, 16'h7FFE);
    {ev, ip1} = {p, 1'b1};
    @(negedge ref_clk);
    ev = 16'h0000;
    rchk(7'h78, p | 16'h8001);
    {i2clr, ip1} = 2'b10;
    @(negedge ref_clk);
    i2clr = 1'b0;
    rchk(7'h78, 16'h0000);
    thrb_host_i.wr(7'h60, 16'h00C0);
    chk("ext_cfg_a", 16'h00C0, cfga);
    p = 16'($urandom());
    thrb_host_i.wr(7'h7C, p);
    for (int i = 0; i < 2; i++) begin
      {isqw, isqv, isqe} = {16'($urandom()) | 16'h0001, i == 0, 1'b1};
      @(negedge ref_clk);
      isqe = 1'b0;
      chk("isq_wr", 16'(i), {15'h0000, isq_wr});
    end
    chk("isq_addr", p, isq_addr);
    chk("isq_data", isqw, isq_data);
    rchk(7'h7C, p + 16'h0001);
    op_mode = thrb_pkg::THRB_MODE_BC;
    {gap, mload} = {16'h0003, 1'b1};
    @(negedge ref_clk);
    mload = 1'b0;
    repeat (30) @(negedge ref_clk);
    rchk(7'h30, 16'h0002);
    thrb_host_i.wr(7'h2C, 16'h0001);
    for (n = 0; frame_done !== 1'b1 && n < 2600; n++) @(negedge ref_clk);
    chk("frame_done", 16'h0001, {15'h0000, n >= 2498 && n <= 2502});
    $display("Test events and timers done");
    stop_test();
  end
  initial begin
    #200000;
    errors++;
    stop_test();
  end
endmodule : tb_terminal_host_register_bank
